/* File: common/ods_pkg.sv */
// Constants and types of the octal driver serial control port
// Summary of operation
// - A one shifted in for a channel commands it off at select rise.
// - A zero shifted in for a channel commands it on at select rise.
// - Frame is eight bits; first bit is channel seven, last is zero.
// - While selected, one input bit enters the shift register per rise.
// - Shift register counts as full after eight bits in a frame.
// - Serial output is released while deselected, driven while selected.
// - Device changes serial output on clock rise; master samples on fall.
// - Channel off without fault reports a high status bit.
// - Channel on without fault reports a low status bit.
// - Both words shift MSB first; status leaves as commands enter.
// - The output reset input does not touch the serial output.
// - Select rise queues the shift register word in a FIFO ahead of the output latches.
// - Select fall freezes every channel's drain status; the first clock rise of the frame loads it into the shifter.
// - While deselected, serial clock and input are ignored.
`default_nettype none
package ods_pkg;

    localparam int CH_COUNT = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BITS_PER_FRAME = 4'h8;
    localparam logic [3:0] BITS_RESET = 4'h0;
    localparam logic [7:0] CMD_ALL_OFF = 8'hff;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'hff;
    localparam logic [7:0] CHAN_OFF = 8'h00;
    localparam logic [2:0] SYNC_HIGH = 3'h7;
    localparam logic [2:0] SYNC_LOW = 3'h0;

    typedef enum logic [1:0] {
        ODS_IDLE = 2'h0,
        ODS_FRAME = 2'h1,
        ODS_PUSH = 2'h3
    } ods_state_t;

endpackage
`default_nettype wire

/* File: rtl/ods_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`default_nettype none
module ods_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } ods_fifo_state_t;

    ods_fifo_state_t q;
    ods_fifo_state_t d;
    logic push;
    logic pop;

    assign o_wr_ready = (q.count != CW'(DEPTH));
    assign o_rd_valid = (q.count != '0);
    assign o_rd_data = q.mem[q.rd_ptr];
    assign push = i_wr_valid && o_wr_ready;
    assign pop = o_rd_valid && i_rd_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr_ptr] = i_wr_data;
            d.wr_ptr = (q.wr_ptr == PW'(DEPTH - 1)) ? '0 : q.wr_ptr + 1'b1;
        end
        if (pop) begin
            d.rd_ptr = (q.rd_ptr == PW'(DEPTH - 1)) ? '0 : q.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            d.count = q.count + 1'b1;
        end else if (pop && !push) begin
            d.count = q.count - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/ods_serial_port.sv */
// Serial command and drain status port of the octal low-side driver
`default_nettype none
module ods_serial_port (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_select_n,
    input wire logic i_serial_in,
    output logic o_serial_out,
    output logic o_serial_out_oe_n,
    input wire logic [7:0] i_drain_high,
    input wire logic i_out_reset_n,
    input wire logic i_update_hold,
    output logic [7:0] o_channel_output,
    output logic o_frame_done,
    output logic o_frame_bad,
    output logic [3:0] o_frame_bits,
    output logic o_cmd_ready
);

    // ************************************************************
    // Link domain state (serial clock)
    // ************************************************************
    typedef struct packed {
        logic [7:0] shift;
        logic [3:0] bits;
        logic so;
        logic seen;
    } ods_link_t;

    // ************************************************************
    // System domain state
    // ************************************************************
    typedef struct packed {
        ods_pkg::ods_state_t state;
        logic [2:0] sel_sync;
        logic sel_low;
        logic [2:0] rst_sync;
        logic out_reset;
        logic [7:0] drain_s1;
        logic [7:0] drain_s2;
        logic [7:0] drain_s3;
        logic [7:0] drain;
        logic [7:0] status_snap;
        logic frame_tog;
        logic [3:0] bits_start;
        logic [7:0] word;
        logic [3:0] nbits;
        logic [7:0] cmd;
        logic [7:0] chan;
        logic done;
        logic bad;
        logic [3:0] last_bits;
    } ods_sys_t;

    ods_link_t lq;
    ods_link_t ld;
    ods_sys_t sq;
    ods_sys_t sd;

    logic fifo_wr_valid;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    logic fifo_rd_ready;
    logic [7:0] fifo_rd_data;

    // ************************************************************
    // Serial output pin
    // ************************************************************
    // Driver follows select only; output reset has no path here
    assign o_serial_out_oe_n = i_select_n;
    assign o_serial_out = lq.so;

    // ************************************************************
    // Link domain shifting
    // ************************************************************
    // Values read from the system domain (status_snap, frame_tog) are
    // frozen from shortly after select falls until the frame ends, so
    // they are stable words by the first clock rise of a frame.
    always_comb begin
        ld = lq;
        if (!i_select_n) begin
            if (sq.frame_tog != lq.seen) begin
                // First rise of a frame: start from the status snapshot
                ld.so = sq.status_snap[7];
                ld.shift = {sq.status_snap[6:0], i_serial_in};
                ld.seen = sq.frame_tog;
            end else begin
                ld.so = lq.shift[7];
                ld.shift = {lq.shift[6:0], i_serial_in};
            end
            // Free running count; frame length is a difference
            ld.bits = lq.bits + 1'b1;
        end
    end

    always_ff @(posedge i_sclk or posedge i_reset) begin
        if (i_reset) begin
            lq.shift <= ods_pkg::SHIFT_RESET;
            lq.bits <= ods_pkg::BITS_RESET;
            lq.so <= 1'b0;
            lq.seen <= 1'b0;
        end else begin
            lq <= ld;
        end
    end

    // ************************************************************
    // Command FIFO between frame capture and output latches
    // ************************************************************
    assign fifo_wr_valid = (sq.state == ods_pkg::ODS_PUSH);
    assign fifo_rd_ready = !i_update_hold;
    assign o_cmd_ready = fifo_wr_ready;

    ods_fifo #(
        .WIDTH(ods_pkg::CH_COUNT),
        .DEPTH(ods_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_wr_valid(fifo_wr_valid),
        .o_wr_ready(fifo_wr_ready),
        .i_wr_data(sq.word),
        .o_rd_valid(fifo_rd_valid),
        .i_rd_ready(fifo_rd_ready),
        .o_rd_data(fifo_rd_data)
    );

    // ************************************************************
    // System domain control
    // ************************************************************
    always_comb begin
        sd = sq;
        sd.done = 1'b0;
        sd.bad = 1'b0;

        // Pin synchronisers; a change counts when stages two and three agree
        sd.sel_sync = {sq.sel_sync[1:0], i_select_n};
        if (sq.sel_sync[1] == sq.sel_sync[2]) begin
            sd.sel_low = !sq.sel_sync[2];
        end
        sd.rst_sync = {sq.rst_sync[1:0], i_out_reset_n};
        if (sq.rst_sync[1] == sq.rst_sync[2]) begin
            sd.out_reset = !sq.rst_sync[2];
        end
        sd.drain_s1 = i_drain_high;
        sd.drain_s2 = sq.drain_s1;
        sd.drain_s3 = sq.drain_s2;
        for (int i = 0; i < ods_pkg::CH_COUNT; i++) begin
            if (sq.drain_s2[i] == sq.drain_s3[i]) begin
                sd.drain[i] = sq.drain_s3[i];
            end
        end

        case (sq.state)
            ods_pkg::ODS_IDLE: begin
                if (sq.sel_low) begin
                    // Select fell: freeze status and open a frame
                    // Token always differs from the link's last seen one,
                    // so a frame without any clock rise cannot mask the
                    // status load of the next frame
                    sd.frame_tog = !lq.seen;
                    sd.bits_start = lq.bits;
                    sd.state = ods_pkg::ODS_FRAME;
                end else begin
                    // Drain high means off, low means on
                    sd.status_snap = sq.drain;
                end
            end
            ods_pkg::ODS_FRAME: begin
                if (!sq.sel_low) begin
                    // Select rose: take the eight bits held now
                    sd.word = lq.shift;
                    sd.nbits = lq.bits - sq.bits_start;
                    sd.state = ods_pkg::ODS_PUSH;
                end
            end
            ods_pkg::ODS_PUSH: begin
                // Stalls here while the FIFO is full
                if (fifo_wr_ready) begin
                    sd.done = 1'b1;
                    sd.bad = (sq.nbits != ods_pkg::BITS_PER_FRAME);
                    sd.last_bits = sq.nbits;
                    sd.state = ods_pkg::ODS_IDLE;
                end
            end
            default: begin
                sd.state = ods_pkg::ODS_IDLE;
            end
        endcase

        // Output latches take each command word in order
        if (fifo_rd_valid && fifo_rd_ready) begin
            sd.cmd = fifo_rd_data;
        end

        // Bit high = off, bit low = on; output reset forces all off
        if (sq.out_reset) begin
            sd.chan = ods_pkg::CHAN_OFF;
        end else begin
            sd.chan = ~sq.cmd;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            sq.state <= ods_pkg::ODS_IDLE;
            sq.sel_sync <= ods_pkg::SYNC_HIGH;
            sq.sel_low <= 1'b0;
            sq.rst_sync <= ods_pkg::SYNC_HIGH;
            sq.out_reset <= 1'b0;
            sq.drain_s1 <= ods_pkg::STATUS_RESET;
            sq.drain_s2 <= ods_pkg::STATUS_RESET;
            sq.drain_s3 <= ods_pkg::STATUS_RESET;
            sq.drain <= ods_pkg::STATUS_RESET;
            sq.status_snap <= ods_pkg::STATUS_RESET;
            sq.frame_tog <= 1'b0;
            sq.bits_start <= ods_pkg::BITS_RESET;
            sq.word <= ods_pkg::CMD_ALL_OFF;
            sq.nbits <= ods_pkg::BITS_RESET;
            sq.cmd <= ods_pkg::CMD_ALL_OFF;
            sq.chan <= ods_pkg::CHAN_OFF;
            sq.done <= 1'b0;
            sq.bad <= 1'b0;
            sq.last_bits <= ods_pkg::BITS_RESET;
        end else begin
            sq <= sd;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_channel_output = sq.chan;
    assign o_frame_done = sq.done;
    assign o_frame_bad = sq.bad;
    assign o_frame_bits = sq.last_bits;

endmodule
`default_nettype wire

/* File: bench/ods_serial_port_assertions.sv */
// Port checker of the serial control port
`default_nettype none
module ods_serial_port_checker (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_select_n,
    input wire logic i_out_reset_n,
    input wire logic i_update_hold,
    input wire logic o_serial_out_oe_n,
    input wire logic [7:0] o_channel_output,
    input wire logic o_frame_done,
    input wire logic o_frame_bad,
    input wire logic [3:0] o_frame_bits
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    a_oe_follows_sel: assert property (
        o_serial_out_oe_n == i_select_n)
        else $error("serial output enable differs from select");
    a_bad_needs_done: assert property (
        o_frame_bad |-> o_frame_done)
        else $error("bad frame flag without frame done");
    a_done_one_cycle: assert property (
        o_frame_done |=> !o_frame_done)
        else $error("frame done longer than one cycle");
    a_done_after_rise: assert property (
        o_frame_done |-> i_select_n && $past(i_select_n, 3))
        else $error("frame done without select rise");
    a_bits_on_done: assert property (
        $changed(o_frame_bits) |-> o_frame_done)
        else $error("bit count changed outside frame done");
    a_bad_count_eight: assert property (
        o_frame_done |-> o_frame_bad == (o_frame_bits != 4'h8))
        else $error("bad frame flag disagrees with bit count");
    a_chan_stable_sel: assert property (
        (!i_select_n && i_out_reset_n && !i_update_hold) [*8]
        |-> $stable(o_channel_output))
        else $error("channels changed while selected");
    a_out_reset_off: assert property (
        !i_out_reset_n [*6] |-> o_channel_output == 8'h00)
        else $error("channels not off under output reset");
endmodule
bind ods_serial_port ods_serial_port_checker i_ods_serial_port_checker (
    .i_clk_sys, .i_reset, .i_select_n, .i_out_reset_n, .i_update_hold,
    .o_serial_out_oe_n, .o_channel_output, .o_frame_done, .o_frame_bad,
    .o_frame_bits);
`default_nettype wire

/* File: bench/ods_spi_master.sv */
// Serial master model for the control port
`default_nettype none
module ods_spi_master (
    output logic o_sclk,
    output logic o_select_n,
    output logic o_serial_in,
    input wire logic i_serial_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_sclk = 1'b0;
        o_select_n = 1'b1;
        o_serial_in = 1'b0;
    end
    // n bits of cmd, MSB first; status taken on falling edges
    task automatic frame(input logic [15:0] cmd, input int n,
            output logic [15:0] st);
        st = 16'h0000;
        #200 o_sclk = 1'b1;
        #7.5 o_sclk = 1'b0;
        #20 o_select_n = 1'b0;
        #80;
        for (int k = n - 1; k >= 0; k--) begin
            o_serial_in = cmd[k];
            #7.5 o_sclk = 1'b1;
            #7.5 o_sclk = 1'b0;
            st = {st[14:0], i_serial_out};
        end
        #20 o_select_n = 1'b1;
        o_serial_in = ~o_serial_in;
        // Stray clock after deselect, before the word is taken
        #7.5 o_sclk = 1'b1;
        #7.5 o_sclk = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: bench/ods_serial_port_tb_top.sv */
// Testbench of the serial control port
`default_nettype none
module ods_serial_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk_sys, i_reset, i_out_reset_n, i_update_hold;
    logic sclk, sel_n, si, so, oe_n, done, bad, ready;
    logic [7:0] drain, chan;
    logic [3:0] bits;
    logic [15:0] st;
    logic so_pin;
    int bad_count = 0;
    int comparisons = 0;
    ods_serial_port i_ods_serial_port (.i_clk_sys(i_clk_sys),
        .i_reset(i_reset), .i_sclk(sclk), .i_select_n(sel_n),
        .i_serial_in(si), .o_serial_out(so), .o_serial_out_oe_n(oe_n),
        .i_drain_high(drain), .i_out_reset_n(i_out_reset_n),
        .i_update_hold(i_update_hold), .o_channel_output(chan),
        .o_frame_done(done), .o_frame_bad(bad), .o_frame_bits(bits),
        .o_cmd_ready(ready));
    // Released pin shows the inverse of the last driven bit
    assign so_pin = oe_n ? ~so : so;
    ods_spi_master i_ods_spi_master (.o_sclk(sclk), .o_select_n(sel_n),
        .o_serial_in(si), .i_serial_out(so_pin));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    // ****
    // Helpers
    // ****
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic set_drain(input logic [7:0] v);
        @(posedge i_clk_sys);
        drain <= v;
        cyc(6);
    endtask
    task automatic send(input logic [15:0] cmd, input int n);
        int w;
        i_ods_spi_master.frame(cmd, n, st);
        w = 0;
        while (done !== 1'b1 && w < 30) begin
            cyc(1);
            w++;
        end
        chk({15'h0000, done}, 16'h0001);
        chk({12'h000, bits}, n[15:0]);
        chk({15'h0000, bad}, {15'h0000, n != 8});
        chk({15'h0000, oe_n}, 16'h0001);
        cyc(4);
    endtask
    task automatic final_report();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic tc_cmd();
        set_drain(8'ha5);
        send(16'h003c, 8);
        chk(st, 16'h00a5);
        chk({8'h00, chan}, 16'h00c3);
    endtask
    task automatic tc_short_long();
        set_drain(8'h5a);
        send(16'h0013, 5);
        chk(st, 16'h000b);
        chk({8'h00, chan}, 16'h00ac);
        send(16'h02c3, 10);
        chk(st, 16'h016a);
        chk({8'h00, chan}, 16'h003c);
        send(16'h0000, 0);
        chk({8'h00, chan}, 16'h003c);
        send(16'h00ff, 8);
        chk(st, 16'h005a);
        chk({8'h00, chan}, 16'h0000);
    endtask
    task automatic tc_out_reset();
        @(posedge i_clk_sys);
        i_out_reset_n <= 1'b0;
        set_drain(8'hf0);
        chk({8'h00, chan}, 16'h0000);
        send(16'h000f, 8);
        chk(st, 16'h00f0);
        @(posedge i_clk_sys);
        i_out_reset_n <= 1'b1;
        cyc(8);
        chk({8'h00, chan}, 16'h00f0);
    endtask
    task automatic tc_hold();
        @(posedge i_clk_sys);
        i_update_hold <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            send(16'h0010 + i[15:0], 8);
        end
        chk({15'h0000, ready}, 16'h0000);
        chk({8'h00, chan}, 16'h00f0);
        @(posedge i_clk_sys);
        i_update_hold <= 1'b0;
        cyc(20);
        chk({15'h0000, ready}, 16'h0001);
        chk({8'h00, chan}, 16'h00e8);
    endtask
    initial begin
        i_reset = 1'b1;
        i_out_reset_n = 1'b1;
        i_update_hold = 1'b0;
        drain = 8'hff;
        repeat (2) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        cyc(6);
        tc_cmd();
        tc_short_long();
        tc_out_reset();
        tc_hold();
        final_report();
    end
    initial begin
        #50000;
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
